// File: core/sfoc_regs.svh
`ifndef SFOC_REGS_SVH
`define SFOC_REGS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SFOC_CTL_BASE      8'h10
`define SFOC_SPAN_BASE     8'h14
`define SFOC_WORD_SEL      7:2
`define SFOC_LANE_SEL      1:0

// ****************************************************************
// output_frame_control field positions
// ****************************************************************
`define SFOC_CTL_CHIP_ID   14
`define SFOC_CTL_SUP_HI    13
`define SFOC_CTL_SUP_LO    12
`define SFOC_CTL_IN_HI     11
`define SFOC_CTL_IN_LO     10
`define SFOC_CTL_SPAN      8
`define SFOC_CTL_PARITY    3
`define SFOC_CTL_PAT_HI    2
`define SFOC_CTL_PAT_LO    0

// ****************************************************************
// reference_and_span_control field positions
// ****************************************************************
`define SFOC_REF_OFF       6
`define SFOC_SPAN_HI       3
`define SFOC_SPAN_LO       0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define SFOC_RST_WORD      32'h0000_0000
`define SFOC_RST_SPAN      4'h0
`define SFOC_RD_UNMAPPED   8'h00
`define SFOC_SPAN_BI_LAST  4'h4
`define SFOC_SPAN_UNI_1ST  4'h8
`define SFOC_SPAN_UNI_LAST 4'hB

// ****************************************************************
// Frame geometry and test patterns
// ****************************************************************
`define SFOC_VALUE_W       12
`define SFOC_FRAME_W       26
`define SFOC_LEN_W         5
`define SFOC_PAT_ZERO      12'h000
`define SFOC_PAT_ONE       12'hFFF
`define SFOC_PAT_ALT1      12'h555
`define SFOC_PAT_ALT2      12'h333

`endif

// File: core/sfoc_pkg.sv
`include "sfoc_regs.svh"

package sfoc_pkg;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [1:0] {
        SFOC_SEL_NONE,
        SFOC_SEL_HIGH,
        SFOC_SEL_LOW,
        SFOC_SEL_BOTH
    } sfoc_flag_sel_e;

    typedef struct packed {
        logic           chip_id_app;
        sfoc_flag_sel_e supply_app;
        sfoc_flag_sel_e input_app;
        logic           span_app;
        logic           parity_app;
        logic [2:0]     pattern;
    } sfoc_ctl_s;

    typedef struct packed {
        logic supply_hi;
        logic supply_lo;
        logic input_hi;
        logic input_lo;
    } sfoc_flags_s;

    typedef struct packed {
        logic [`SFOC_FRAME_W-1:0] bits;
        logic [`SFOC_LEN_W-1:0]   len;
    } sfoc_frame_s;

    typedef struct packed {
        sfoc_ctl_s                ctl;
        logic                     ref_off;
        logic [3:0]               span;
        logic [`SFOC_VALUE_W-1:0] sample;
        logic [2:0]               sclk_sync;
        logic                     sclk_lvl;
        logic [2:0]               cs_sync;
        logic                     cs_lvl;
        logic [`SFOC_FRAME_W-1:0] shift;
        logic                     sdo;
        logic [7:0]               rdata;
    } sfoc_state_s;

endpackage : sfoc_pkg

// File: core/sfoc_frame_build.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfoc_regs.svh"

module sfoc_frame_build (
    input  wire sfoc_pkg::sfoc_ctl_s   ctl,
    input  wire logic [`SFOC_VALUE_W-1:0] sample,
    input  wire logic [3:0]            chip_id,
    input  wire sfoc_pkg::sfoc_flags_s flags,
    input  wire logic [3:0]            span,
    output var  sfoc_pkg::sfoc_frame_s frame
);

    // ************************************************************
    // Append one bit at the low end of the growing frame
    // ************************************************************
    function automatic sfoc_pkg::sfoc_frame_s app1(
        input sfoc_pkg::sfoc_frame_s f,
        input logic                  b
    );
        sfoc_pkg::sfoc_frame_s r;
        r.bits = {f.bits[`SFOC_FRAME_W-2:0], b};
        r.len  = f.len + `SFOC_LEN_W'(1);
        return r;
    endfunction : app1

    logic [`SFOC_VALUE_W-1:0] value;
    sfoc_pkg::sfoc_frame_s    acc;
    logic                     par_value;
    logic                     par_frame;

    // Value field: live sample or a fixed pattern
    always_comb begin
        case (ctl.pattern)
            3'h4:    value = `SFOC_PAT_ZERO;                   // see [R11]
            3'h5:    value = `SFOC_PAT_ONE;                    // see [R11]
            3'h6:    value = `SFOC_PAT_ALT1;                   // see [R12]
            3'h7:    value = `SFOC_PAT_ALT2;                   // see [R12]
            default: value = sample;                           // see [R10]
        endcase
    end

    // Build right-justified, then left-justify so the MSB leads
    always_comb begin
        acc.bits = {{(`SFOC_FRAME_W-`SFOC_VALUE_W){1'b0}}, value};
        acc.len  = `SFOC_LEN_W'(`SFOC_VALUE_W);
        par_value = ^value;                                    // see [R7]
        if (ctl.chip_id_app) begin                             // see [R2]
            for (int i = 3; i >= 0; i--) begin
                acc = app1(acc, chip_id[i]);
            end
        end
        // High flag goes first when both are selected
        if (ctl.supply_app[0]) acc = app1(acc, flags.supply_hi); // see [R3]
        if (ctl.supply_app[1]) acc = app1(acc, flags.supply_lo); // see [R3]
        if (ctl.input_app[0])  acc = app1(acc, flags.input_hi);  // see [R4]
        if (ctl.input_app[1])  acc = app1(acc, flags.input_lo);  // see [R4]
        if (ctl.span_app) begin                                // see [R5]
            for (int i = 3; i >= 0; i--) begin
                acc = app1(acc, span[i]);
            end
        end
        // Frame parity covers everything ahead of the parity pair
        par_frame = ^acc.bits;                                 // see [R8]
        if (ctl.parity_app) begin                              // see [R6] [R18]
            acc = app1(acc, par_value);
            acc = app1(acc, par_frame);                        // see [R9]
        end
        frame.len  = acc.len;
        frame.bits = acc.bits << (`SFOC_LEN_W'(`SFOC_FRAME_W) - acc.len);
    end

endmodule : sfoc_frame_build

`default_nettype wire

// File: core/sfoc_frame_ctl.sv
// Overview of operation
// [R1] Bits 31-16 of output_frame_control always read zero.
// [R2] Bit 14 set appends the 4-bit chip id to the frame.
// [R3] Bits 13-12 pick which supply flags are appended: none, high, low, both.
// [R4] Bits 11-10 pick which input flags are appended: none, high, low, both.
// [R5] Bit 8 set appends the 4-bit span code to the frame.
// [R6] Bit 3 set appends two parity bits at the frame's low end.
// [R7] First parity bit is even parity over the value bits only.
// [R8] Second parity bit is even parity over the whole frame; the code covers only the bits ahead of the parity pair.
// [R9] Parity makes the frame two bits longer; host clocks them out.
// [R10] Pattern field MSB zero sends the live conversion value.
// [R11] Pattern 100b sends all zeros, 101b all ones.
// [R12] Pattern 110b alternates single bits, 111b alternates bit pairs.
// [R13] Span register spans byte addresses 14h to 17h, low byte first.
// [R14] Span register holds reference-off bit 6 and span code 3-0.
// [R15] Power-on fields clear only on power-on reset, not application reset.
// [R16] Reference-off zero keeps the on-chip reference on, one turns off.
// [R17] Span codes 0-4 bipolar, 8-11 unipolar, others unused.
// [R18] Appended order: chip id, supply, input, span code, parity pair.
// [R19] Writes to reserved bits are ignored; they stay zero.
`timescale 1ns/1ps
`default_nettype none
`include "sfoc_regs.svh"

module sfoc_frame_ctl (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     por_n,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    input  wire logic [`SFOC_VALUE_W-1:0] conv_data,
    input  wire logic                     conv_valid,
    input  wire logic [3:0]               chip_id,
    input  wire sfoc_pkg::sfoc_flags_s    alarm_flags,
    input  wire logic                     link_sclk,
    input  wire logic                     link_cs_n,
    output logic                          serial_out_lines,
    output logic                          serial_out_lines_oe,
    output logic                          onchip_reference_off,
    output logic [3:0]                    span_code,
    output logic                          span_bipolar,
    output logic                          span_valid
);

    // ************************************************************
    // Register images and byte lanes
    // ************************************************************

    // Control word as software sees it; reserved bits are constant zero
    function automatic logic [31:0] ctl_image(
        input sfoc_pkg::sfoc_ctl_s c
    );
        logic [31:0] w;
        w = `SFOC_RST_WORD;                                    // see [R1]
        w[`SFOC_CTL_CHIP_ID] = c.chip_id_app;
        w[`SFOC_CTL_SUP_HI:`SFOC_CTL_SUP_LO] = c.supply_app;
        w[`SFOC_CTL_IN_HI:`SFOC_CTL_IN_LO]   = c.input_app;
        w[`SFOC_CTL_SPAN]    = c.span_app;
        w[`SFOC_CTL_PARITY]  = c.parity_app;
        w[`SFOC_CTL_PAT_HI:`SFOC_CTL_PAT_LO] = c.pattern;
        return w;
    endfunction : ctl_image

    // Only the stored fields are picked out, so reserved writes vanish
    function automatic sfoc_pkg::sfoc_ctl_s ctl_fields(
        input logic [31:0] w
    );
        sfoc_pkg::sfoc_ctl_s c;
        c.chip_id_app = w[`SFOC_CTL_CHIP_ID];                  // see [R19]
        c.supply_app  = sfoc_pkg::sfoc_flag_sel_e'(
                            w[`SFOC_CTL_SUP_HI:`SFOC_CTL_SUP_LO]);
        c.input_app   = sfoc_pkg::sfoc_flag_sel_e'(
                            w[`SFOC_CTL_IN_HI:`SFOC_CTL_IN_LO]);
        c.span_app    = w[`SFOC_CTL_SPAN];
        c.parity_app  = w[`SFOC_CTL_PARITY];
        c.pattern     = w[`SFOC_CTL_PAT_HI:`SFOC_CTL_PAT_LO];
        return c;
    endfunction : ctl_fields

    // Span word image
    function automatic logic [31:0] span_image(
        input logic       off,
        input logic [3:0] code
    );
        logic [31:0] w;
        w = `SFOC_RST_WORD;                                    // see [R14]
        w[`SFOC_REF_OFF] = off;
        w[`SFOC_SPAN_HI:`SFOC_SPAN_LO] = code;
        return w;
    endfunction : span_image

    // Byte lane 0 holds bits 7-0, lane 3 bits 31-24
    function automatic logic [7:0] byte_of(
        input logic [31:0] w,
        input logic [1:0]  lane
    );
        return w[lane*8 +: 8];                                 // see [R13]
    endfunction : byte_of

    function automatic logic [31:0] put_byte(
        input logic [31:0] w,
        input logic [1:0]  lane,
        input logic [7:0]  b
    );
        logic [31:0] r;
        r = w;
        r[lane*8 +: 8] = b;
        return r;
    endfunction : put_byte

    // Nine spans: five bipolar, four unipolar
    function automatic logic span_used(
        input logic [3:0] code
    );
        return (code <= `SFOC_SPAN_BI_LAST) ||
               ((code >= `SFOC_SPAN_UNI_1ST) &&
                (code <= `SFOC_SPAN_UNI_LAST));
    endfunction : span_used

    // ************************************************************
    // State
    // ************************************************************
    sfoc_pkg::sfoc_state_s st_r;
    sfoc_pkg::sfoc_state_s st_nxt;
    sfoc_pkg::sfoc_frame_s frame;
    logic                  sclk_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  sel_ctl;
    logic                  sel_span;
    logic [31:0]           wr_word;

    // ************************************************************
    // Frame assembly
    // ************************************************************

    // Pure combinational build from the settings in force right now
    sfoc_frame_build u_build (
        .ctl     (st_r.ctl),
        .sample  (st_r.sample),
        .chip_id (chip_id),
        .flags   (alarm_flags),
        .span    (st_r.span),
        .frame   (frame)
    );

    // ************************************************************
    // Link edge detection
    // ************************************************************

    // Stage 2 and 3 must agree before a change counts; filters glitches
    always_comb begin
        sclk_fall = (st_r.sclk_sync[2] == st_r.sclk_sync[1]) &&
                    !st_r.sclk_sync[2] && st_r.sclk_lvl;
        cs_fall   = (st_r.cs_sync[2] == st_r.cs_sync[1]) &&
                    !st_r.cs_sync[2] && st_r.cs_lvl;
        cs_rise   = (st_r.cs_sync[2] == st_r.cs_sync[1]) &&
                    st_r.cs_sync[2] && !st_r.cs_lvl;
    end

    // Address decode on the word part of the byte address
    always_comb begin
        sel_ctl  = reg_addr[`SFOC_WORD_SEL] ==
                   (`SFOC_CTL_BASE >> 2);
        sel_span = reg_addr[`SFOC_WORD_SEL] ==
                   (`SFOC_SPAN_BASE >> 2);
        wr_word  = `SFOC_RST_WORD;
        if (sel_ctl) begin
            wr_word = put_byte(ctl_image(st_r.ctl),
                               reg_addr[`SFOC_LANE_SEL], reg_wdata);
        end else if (sel_span) begin
            wr_word = put_byte(span_image(st_r.ref_off, st_r.span),
                               reg_addr[`SFOC_LANE_SEL], reg_wdata);
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // Synchronisers: first stage feeds only the second
        st_nxt.sclk_sync = {st_r.sclk_sync[1:0], link_sclk};
        st_nxt.cs_sync   = {st_r.cs_sync[1:0], link_cs_n};
        if (st_r.sclk_sync[2] == st_r.sclk_sync[1]) begin
            st_nxt.sclk_lvl = st_r.sclk_sync[2];
        end
        if (st_r.cs_sync[2] == st_r.cs_sync[1]) begin
            st_nxt.cs_lvl = st_r.cs_sync[2];
        end

        // Latest conversion result waits for the next frame
        if (conv_valid) begin
            st_nxt.sample = conv_data;
        end

        // Frame is frozen at select; later writes hit the next frame
        if (cs_fall) begin
            st_nxt.shift = frame.bits;                         // see [R18]
            st_nxt.sdo   = frame.bits[`SFOC_FRAME_W-1];
        end else if (sclk_fall && !st_r.cs_lvl) begin
            // Zeros trail once the frame has run out
            st_nxt.shift = {st_r.shift[`SFOC_FRAME_W-2:0], 1'b0}; // see [R9]
            st_nxt.sdo   = st_r.shift[`SFOC_FRAME_W-2];
        end else if (cs_rise) begin
            st_nxt.sdo   = 1'b0;
        end

        // Register writes; only stored fields are kept
        if (reg_wr && sel_ctl) begin
            st_nxt.ctl = ctl_fields(wr_word);                  // see [R2]
        end
        if (reg_wr && sel_span) begin
            st_nxt.ref_off = wr_word[`SFOC_REF_OFF];           // see [R14]
            st_nxt.span    = wr_word[`SFOC_SPAN_HI:`SFOC_SPAN_LO];
        end

        // Reads return the old value when a write hits the same cycle
        if (reg_rd) begin
            if (sel_ctl) begin
                st_nxt.rdata = byte_of(ctl_image(st_r.ctl),
                                       reg_addr[`SFOC_LANE_SEL]); // see [R1]
            end else if (sel_span) begin
                st_nxt.rdata = byte_of(span_image(st_r.ref_off, st_r.span),
                                       reg_addr[`SFOC_LANE_SEL]); // see [R13]
            end else begin
                st_nxt.rdata = `SFOC_RD_UNMAPPED;
            end
        end

        // Application reset spares the power-on fields
        if (!por_n || !rst_n) begin
            st_nxt           = '0;
            st_nxt.ctl       = sfoc_pkg::sfoc_ctl_s'(`SFOC_RST_WORD);
            st_nxt.cs_sync   = '1;
            st_nxt.cs_lvl    = 1'b1;
            if (por_n) begin                                   // see [R15]
                st_nxt.ctl.parity_app = st_r.ctl.parity_app;
                st_nxt.span           = st_r.span;
            end else begin
                st_nxt.span = `SFOC_RST_SPAN;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Both resets are synchronous and handled in the next-state logic
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Pin is driven only while the host holds select low
    always_comb begin
        reg_rdata            = st_r.rdata;
        serial_out_lines     = st_r.sdo;
        serial_out_lines_oe  = !st_r.cs_lvl;
        onchip_reference_off = st_r.ref_off;                   // see [R16]
        span_code            = st_r.span;
        span_bipolar         = !st_r.span[`SFOC_SPAN_HI];      // see [R17]
        span_valid           = span_used(st_r.span);           // see [R17]
    end

endmodule : sfoc_frame_ctl

`default_nettype wire

// File: verif/sfoc_frame_ctl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the frame control block
// ****************************************************************
module sfoc_frame_ctl_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       por_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       link_cs_n,
    input wire logic       serial_out_lines,
    input wire logic       serial_out_lines_oe,
    input wire logic       onchip_reference_off,
    input wire logic [3:0] span_code,
    input wire logic       span_bipolar,
    input wire logic       span_valid
);
    logic [7:0] wd_q;

    // Last write byte
    always_ff @(posedge clk) begin
        wd_q <= reg_wdata;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !por_n);

    AST_RSV_LANES: assert property (
        reg_rd && reg_addr inside {8'h12, 8'h13, 8'h15, 8'h16, 8'h17}
        |=> reg_rdata == 8'h00) else $error("reserved lane not zero");
    AST_CTL_LOW_RSV: assert property (
        reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:4] == 4'h0)
        else $error("control bits 7-4 not zero");
    AST_CTL_HI_RSV: assert property (
        reg_rd && reg_addr == 8'h11
        |=> {reg_rdata[7], reg_rdata[1]} == 2'h0)
        else $error("control bits 15 or 9 not zero");
    AST_SPAN_RD: assert property (
        reg_rd && reg_addr == 8'h14 |=> reg_rdata ==
        {1'h0, $past(onchip_reference_off), 2'h0, $past(span_code)})
        else $error("span register read wrong");
    AST_REF_WR: assert property (
        reg_wr && reg_addr == 8'h14 |=> onchip_reference_off == wd_q[6])
        else $error("reference-off bit not written");
    AST_SPAN_WR: assert property (
        reg_wr && reg_addr == 8'h14 |=> span_code == wd_q[3:0])
        else $error("span code not written");
    AST_BIPOLAR: assert property (
        span_bipolar == !span_code[3]) else $error("bipolar decode wrong");
    AST_VALID: assert property (
        span_valid == (span_code <= 4'h4 ||
        (span_code >= 4'h8 && span_code <= 4'hB)))
        else $error("span valid decode wrong");
    AST_KEEP_SPAN: assert property (
        disable iff (!por_n) !rst_n |=> $stable(span_code))
        else $error("span code lost on application reset");
    AST_REF_CLR: assert property (
        disable iff (!por_n) !rst_n |=> !onchip_reference_off)
        else $error("reference-off not cleared");
    AST_OE_IDLE: assert property (
        link_cs_n [*6] |-> !serial_out_lines_oe && !serial_out_lines)
        else $error("output driven outside a frame");
    AST_OE_ACT: assert property (
        !link_cs_n [*6] |-> serial_out_lines_oe)
        else $error("output not driven inside a frame");
endmodule : sfoc_frame_ctl_chk

bind sfoc_frame_ctl sfoc_frame_ctl_chk u_chk (
    .clk, .rst_n, .por_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .link_cs_n, .serial_out_lines, .serial_out_lines_oe,
    .onchip_reference_off, .span_code, .span_bipolar, .span_valid
);
`default_nettype wire

// File: verif/sfoc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host that clocks frames out of the block
// ****************************************************************
module sfoc_host_model (
    input  wire logic        go,
    input  wire logic [4:0]  nbits,
    input  wire logic        sdo,
    output var  logic        link_sclk,
    output var  logic        link_cs_n,
    output var  logic [26:0] rx,
    output var  logic        done
);
    // Clock idles low between frames
    always begin
        link_sclk = 1'h0;
        link_cs_n = 1'h1;
        rx = 27'h0;
        done = 1'h0;
        wait (go === 1'h1);
        link_cs_n = 1'h0;
        #48;
        repeat (nbits) begin
            link_sclk = 1'h1;
            rx = {rx[25:0], sdo}; // Sampled on the rising edge
            #24;
            link_sclk = 1'h0;
            #24;
        end
        link_cs_n = 1'h1;
        #40;
        done = 1'h1;
        wait (go === 1'h0);
    end
endmodule : sfoc_host_model
`default_nettype wire

// File: verif/test_sample_frame_output_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfoc_regs.svh"
// ****************************************************************
// Bench for the frame control registers
// ****************************************************************
module test_sample_frame_output_config;
    logic                     clk, rst_n, por_n, reg_wr, reg_rd;
    logic [7:0]               reg_addr, reg_wdata, reg_rdata, b;
    logic [`SFOC_VALUE_W-1:0] conv_data;
    logic                     conv_valid, go, done;
    logic [3:0]               chip_id, span_code;
    sfoc_pkg::sfoc_flags_s    alarm_flags;
    logic                     link_sclk, link_cs_n, serial_out_lines;
    logic                     serial_out_lines_oe, onchip_reference_off;
    logic                     span_bipolar, span_valid;
    logic [4:0]               nbits;
    logic [26:0]              rx, e;
    logic [31:0]              w;
    int                       n_mismatch, total_checks, len;
    logic [15:0]              cases [10] = '{16'h0000, 16'h000C,
        16'h000D, 16'h000E, 16'h000F, 16'h0004, 16'h5908, 16'h240D,
        16'h3C0E, 16'h7D0B};

    sfoc_frame_ctl dut (.clk, .rst_n, .por_n, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .conv_data, .conv_valid,
        .chip_id, .alarm_flags, .link_sclk, .link_cs_n, .serial_out_lines,
        .serial_out_lines_oe, .onchip_reference_off, .span_code,
        .span_bipolar, .span_valid);
    sfoc_host_model host (.go, .nbits, .sdo(serial_out_lines),
        .link_sclk, .link_cs_n, .rx, .done);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("Mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // One byte per strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata; // Registered answer
    endtask : rd

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            wr(8'(a + i), d[8*i +: 8]);
        end
    endtask : wr32

    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        logic [7:0] t;
        for (int i = 0; i < 4; i++) begin
            rd(8'(a + i), t);
            d[8*i +: 8] = t;
        end
    endtask : rd32

    // Expected stream plus a trailing zero
    function automatic logic [26:0] exp_frame(input logic [15:0] c,
        input logic [3:0] fl, input logic [3:0] sp, output int n);
        logic [11:0] v;
        logic [26:0] f;
        case (c[2:0])
            3'h4: v = 12'h000;
            3'h5: v = 12'hFFF;
            3'h6: v = 12'h555;
            3'h7: v = 12'h333;
            default: v = 12'hA5C;
        endcase
        f = 27'(v);
        n = 12 + 4 * c[14] + c[13] + c[12] + c[11] + c[10] + 4 * c[8]
            + 2 * c[3];
        if (c[14]) f = {f[22:0], 4'h9};
        if (c[12]) f = {f[25:0], fl[3]};
        if (c[13]) f = {f[25:0], fl[2]};
        if (c[10]) f = {f[25:0], fl[1]};
        if (c[11]) f = {f[25:0], fl[0]};
        if (c[8]) f = {f[22:0], sp};
        if (c[3]) f = {f[24:0], ^v, ^f};
        return {f[25:0], 1'h0};
    endfunction : exp_frame

    // One extra bit is read; it must be zero
    task automatic frame(input logic [26:0] exp, input int n);
        @(posedge clk);
        nbits <= 5'(n + 1);
        go <= 1'h1;
        for (int i = 0; i < 400 && done !== 1'h1; i++) @(posedge clk);
        if (done !== 1'h1) begin
            n_mismatch++;
            $display("[ERR] %0t frame never completed", $time);
            finish_test();
        end
        go <= 1'h0;
        check(rx, exp);
    endtask : frame

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        clk = 1'h0;
        {rst_n, por_n, reg_wr, reg_rd, conv_valid, go} = 6'h0;
        {reg_addr, reg_wdata, conv_data, nbits} = 33'h0;
        chip_id = 4'h9;
        alarm_flags = 4'hA;
        n_mismatch = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        por_n <= 1'h1;
        rd32(8'h10, w);
        check(w, 32'h0);
        rd32(8'h14, w);
        check(w, 32'h0);
        wr32(8'h10, 32'hFFFF_FFFF);
        rd32(8'h10, w);
        check(w, 32'h0000_7D0F);
        wr32(8'h14, 32'hFFFF_FFFF);
        rd32(8'h14, w);
        check(w, 32'h0000_004F);
        check(onchip_reference_off, 1);
        rd(8'h20, b);
        check(b, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(8'h14, 8'(i));
            #1 check(span_code, i);
            check(span_bipolar, i < 8);
            check(span_valid, i <= 4 || (i >= 8 && i <= 11));
            check(onchip_reference_off, 0);
        end
        wr(8'h14, 8'h0B);
        @(posedge clk);
        conv_data <= 12'hA5C;
        conv_valid <= 1'h1;
        @(posedge clk);
        conv_valid <= 1'h0;
        for (int k = 0; k < 10; k++) begin
            wr(8'h10, cases[k][7:0]);
            wr(8'h11, cases[k][15:8]);
            alarm_flags <= 4'(k + 5);
            e = exp_frame(cases[k], 4'(k + 5), 4'hB, len);
            frame(e, len);
        end
        wr(8'h14, 8'h4B);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd32(8'h10, w);
        check(w, 32'h0000_0008);
        rd32(8'h14, w);
        check(w, 32'h0000_000B);
        @(posedge clk);
        por_n <= 1'h0;
        repeat (2) @(posedge clk);
        por_n <= 1'h1;
        rd32(8'h14, w);
        check(w, 32'h0);
        finish_test();
    end
endmodule : test_sample_frame_output_config
`default_nettype wire
